// ===== btsd_regs.svh
// Constants for the bit-test-and-skip decoder
`ifndef BTSD_REGS_SVH
`define BTSD_REGS_SVH
`define BTSD_OP_HI 15
`define BTSD_OP_LO 12
`define BTSD_BIT_HI 11
`define BTSD_BIT_LO 9
`define BTSD_ACC_POS 8
`define BTSD_F_HI 7
`define BTSD_F_LO 0
`define BTSD_OP_CLEAR 4'hb
`define BTSD_OP_SET 4'ha
`define BTSD_IDX_LIMIT 8'h5f
`define BTSD_ACC_SPLIT 8'h60
`define BTSD_ACC_HI_PAGE 4'hf
`define BTSD_ACC_LO_PAGE 4'h0
`endif

// ===== btsd_pkg.sv
// Types for the bit-test-and-skip decoder
package btsd_pkg;
  typedef logic [11:0] btsd_addr_t;
  typedef enum logic [1:0] {BTSD_OP_NONE, BTSD_OP_SKIP_CLR, BTSD_OP_SKIP_SET} btsd_op_e;
  typedef enum logic {BTSD_ST_FETCH, BTSD_ST_TEST} btsd_state_e;
  typedef struct packed {
    btsd_state_e state;
    logic skip_pend;
    logic polarity;
    logic [2:0] bit_idx;
    btsd_addr_t mem_addr;
    logic mem_rd;
    logic skip;
    logic exec_idle;
    logic exec_other;
    logic [15:0] other_word;
  } btsd_state_s;
endpackage

// ===== btsd_dec_if.sv
// Operand fields passed from the decoder to the address resolver
`timescale 1ns/1ps
interface btsd_dec_if;
  logic acc_sel;
  logic [7:0] file_addr;
  logic ext_set_en;
  logic [7:0] bank_sel;
  btsd_pkg::btsd_addr_t idx_base;
  btsd_pkg::btsd_addr_t eff_addr;
  modport core (output acc_sel, file_addr, ext_set_en, bank_sel, idx_base, input eff_addr);
  modport resolver (input acc_sel, file_addr, ext_set_en, bank_sel, idx_base, output eff_addr);
endinterface

// ===== btsd_addr_resolve.sv
// Effective data address of the file operand
`timescale 1ns/1ps
`include "btsd_regs.svh"
module btsd_addr_resolve (
  btsd_dec_if.resolver dif // Operand fields in, address out
);
  import btsd_pkg::*;
  always_comb begin
    if (dif.acc_sel) begin
      dif.eff_addr = {dif.bank_sel[3:0], dif.file_addr};
    end else if (dif.ext_set_en && dif.file_addr <= `BTSD_IDX_LIMIT) begin
      // Base plus literal offset; wraps in the 12-bit data space
      dif.eff_addr = btsd_addr_t'(dif.idx_base + {4'h0, dif.file_addr});
    end else if (dif.file_addr < `BTSD_ACC_SPLIT) begin
      dif.eff_addr = {`BTSD_ACC_LO_PAGE, dif.file_addr};
    end else begin
      dif.eff_addr = {`BTSD_ACC_HI_PAGE, dif.file_addr};
    end
  end
endmodule

// ===== btsd_core.sv
// Bit-test-and-skip decode and execute core
`timescale 1ns/1ps
`include "btsd_regs.svh"
module btsd_core (
  input wire logic ref_clk_i, // 40 MHz instruction clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic instr_valid_i, // Fetched word present
  input wire logic [15:0] instr_i, // Fetched instruction word
  output logic instr_ready_o, // Core takes a word this cycle
  input wire logic ext_set_en_i, // Extended instruction set enabled
  input wire logic [7:0] bank_select_register_i, // Bank for selector 1
  input wire btsd_pkg::btsd_addr_t idx_base_i, // Base for indexed literal offset
  output btsd_pkg::btsd_addr_t mem_addr_o, // Data memory read address
  output logic mem_rd_o, // Read strobe, data sampled in the same cycle
  input wire logic [7:0] mem_rdata_i, // Read data
  output logic skip_o, // Pulse: skip taken
  output logic exec_idle_o, // Pulse: discarded word run as idle
  output logic exec_other_o, // Pulse: word is not a bit test
  output logic [15:0] other_word_o // Word handed on with exec_other_o
);
  import btsd_pkg::*;

  function automatic btsd_op_e op_kind(input logic [15:0] w);
    unique case (w[`BTSD_OP_HI:`BTSD_OP_LO])
      `BTSD_OP_CLEAR: op_kind = BTSD_OP_SKIP_CLR;
      `BTSD_OP_SET: op_kind = BTSD_OP_SKIP_SET;
      default: op_kind = BTSD_OP_NONE;
    endcase
  endfunction

  btsd_state_s st_r;
  btsd_state_s st_nxt;
  btsd_dec_if dif ();
  btsd_op_e op;
  logic tested;

  assign dif.acc_sel = instr_i[`BTSD_ACC_POS];
  assign dif.file_addr = instr_i[`BTSD_F_HI:`BTSD_F_LO];
  assign dif.ext_set_en = ext_set_en_i;
  assign dif.bank_sel = bank_select_register_i;
  assign dif.idx_base = idx_base_i;

  btsd_addr_resolve u_resolve (
    .dif(dif.resolver)
  );

  assign op = op_kind(instr_i);
  // One-cycle read latency means a new word is refused while testing
  assign instr_ready_o = (st_r.state == BTSD_ST_FETCH);
  assign tested = mem_rdata_i[st_r.bit_idx];

  always_comb begin
    st_nxt = st_r;
    st_nxt.mem_rd = 1'b0;
    st_nxt.skip = 1'b0;
    st_nxt.exec_idle = 1'b0;
    st_nxt.exec_other = 1'b0;
    unique case (st_r.state)
      BTSD_ST_FETCH: begin
        if (instr_valid_i) begin
          if (st_r.skip_pend) begin
            st_nxt.skip_pend = 1'b0;
            st_nxt.exec_idle = 1'b1;
          end else if (op != BTSD_OP_NONE) begin
            st_nxt.polarity = (op == BTSD_OP_SKIP_SET);
            st_nxt.bit_idx = instr_i[`BTSD_BIT_HI:`BTSD_BIT_LO];
            st_nxt.mem_addr = dif.eff_addr;
            st_nxt.mem_rd = 1'b1;
            st_nxt.state = BTSD_ST_TEST;
          end else begin
            st_nxt.exec_other = 1'b1;
            st_nxt.other_word = instr_i;
          end
        end
      end
      BTSD_ST_TEST: begin
        // Set polarity skips on one, clear polarity on zero
        st_nxt.skip_pend = st_r.polarity ? tested : ~tested;
        st_nxt.skip = st_r.polarity ? tested : ~tested;
        st_nxt.state = BTSD_ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '{state: BTSD_ST_FETCH, other_word: 16'h0000, mem_addr: 12'h000,
                bit_idx: 3'h0, default: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mem_addr_o = st_r.mem_addr;
  assign mem_rd_o = st_r.mem_rd;
  assign skip_o = st_r.skip;
  assign exec_idle_o = st_r.exec_idle;
  assign exec_other_o = st_r.exec_other;
  assign other_word_o = st_r.other_word;
endmodule

// ===== btsd_core_sva.sv
// Assertions on the bit-test-and-skip core ports
`timescale 1ns/1ps
module btsd_core_sva (
  input wire logic ref_clk_i, // Clock
  input wire logic resetn_i, // Reset, active low
  input wire logic instr_valid_i, // Word offered
  input wire logic [15:0] instr_i, // Word
  input wire logic instr_ready_o, // Word taken
  input wire logic ext_set_en_i, // Extended set
  input wire btsd_pkg::btsd_addr_t idx_base_i, // Index base
  input wire btsd_pkg::btsd_addr_t mem_addr_o, // Read address
  input wire logic mem_rd_o, // Read strobe
  input wire logic [7:0] mem_rdata_i, // Read data
  input wire logic skip_o, // Skip pulse
  input wire logic exec_idle_o, // Idle pulse
  input wire logic exec_other_o // Other pulse
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  wire tk = instr_valid_i && instr_ready_o;
  wire tst = tk && instr_i[15:13] == 3'b101;
  wire idx_mode = !instr_i[8] && ext_set_en_i && instr_i[7:0] <= 8'h5f;
  logic [2:0] b_r;
  // Bit index stays put while ready is low, so the test cycle sees it
  always_ff @(posedge ref_clk_i) if (tk) b_r <= instr_i[11:9];
  sequence test_of(logic [3:0] op);
    tk && instr_i[15:12] == op ##1 mem_rd_o;
  endsequence
  read_issue_a: assert property (tst |=> mem_rd_o && !instr_ready_o)
    else $error("no read after bit test");
  skip_set_a: assert property (test_of(4'ha) |=> skip_o == $past(mem_rdata_i[b_r]))
    else $error("skip if set wrong");
  skip_clear_a: assert property (test_of(4'hb) |=> skip_o != $past(mem_rdata_i[b_r]))
    else $error("skip if clear wrong");
  idle_slot_a: assert property (skip_o && tk |=> exec_idle_o && !exec_other_o)
    else $error("skipped word not idled");
  idx_addr_a: assert property (tst && idx_mode |=>
    mem_addr_o == $past(idx_base_i) + $past(instr_i[7:0])) else $error("indexed address wrong");
endmodule
bind btsd_core btsd_core_sva u_sva (.ref_clk_i, .resetn_i, .instr_valid_i, .instr_i,
  .instr_ready_o, .ext_set_en_i, .idx_base_i, .mem_addr_o, .mem_rd_o, .mem_rdata_i,
  .skip_o, .exec_idle_o, .exec_other_o);

// ===== test_bit_test_skip_decode.sv
// Self-checking random bench for the bit-test-and-skip core
`timescale 1ns/1ps
module test_bit_test_skip_decode;
  logic clk = 0, rstn = 0, vld = 0, ext = 0, rd, sk, idl, oth, rdy;
  logic [15:0] w = 0, ow, eow = 0;
  logic [7:0] bank = 0, d = 0;
  logic [11:0] base = 0, ma;
  integer seed = 2, n_mismatch = 0, n_checks = 0, i;
  btsd_core i_dut (.ref_clk_i(clk), .resetn_i(rstn), .instr_valid_i(vld), .instr_i(w),
    .instr_ready_o(rdy), .ext_set_en_i(ext), .bank_select_register_i(bank), .idx_base_i(base),
    .mem_addr_o(ma), .mem_rd_o(rd), .mem_rdata_i(d), .skip_o(sk), .exec_idle_o(idl),
    .exec_other_o(oth), .other_word_o(ow));
  initial forever #12.5 clk = ~clk;
  function automatic logic [11:0] ex_addr(logic [15:0] x);
    if (x[8]) return {bank[3:0], x[7:0]};
    if (ext && x[7:0] <= 8'h5f) return 12'(base + {4'h0, x[7:0]});
    return {(x[7:0] < 8'h60) ? 4'h0 : 4'hf, x[7:0]};
  endfunction
  task automatic chk(logic [15:0] g, logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic run(logic [15:0] x, logic [7:0] r);
    logic s;
    logic [15:0] y;
    s = r[x[11:9]] ^ x[12];
    // Bit 13 cleared keeps the follow-on word out of both bit-test opcodes
    y = 16'($random(seed)) & 16'hdfff;
    @(posedge clk) #1 w = x;
    vld = 1;
    @(posedge clk) #1 vld = 0;
    d = r;
    chk(rd, 16'h0001);
    chk(ma, ex_addr(x));
    @(posedge clk) #1 chk(sk, s);
    w = y;
    vld = 1;
    @(posedge clk) #1 vld = 0;
    d = ~r;
    chk(idl, s);
    chk(oth, !s);
    if (!s) eow = y;
    chk(ow, eow);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rstn = 1;
    for (i = 0; i < 60; i++) begin
      if (i == 30) begin
        // Mid-run reset: outputs fall back to their idle values at once
        rstn = 0;
        #1 chk(ma, 16'h0000);
        chk(ow, 16'h0000);
        chk(rdy, 16'h0001);
        eow = 16'h0000;
        @(posedge clk) #1 rstn = 1;
      end
      ext = (i < 4) | 1'($random(seed));
      bank = 8'($random(seed));
      base = 12'($random(seed));
      w = {3'b101, 13'($random(seed))};
      if (i < 4) w[8:0] = {1'b0, 8'h5f + 8'(i & 1)}; // Split edge 5Fh/60h
      run(w, 8'($random(seed)));
      $display("test %0d done", i);
    end
    give_verdict();
  end
  initial begin
    #30000 n_mismatch++;
    give_verdict();
  end
endmodule
